// ==== common/oss_pkg.sv ====
// Package of constants and types for the output sequence program controller.
package oss_pkg;

    // Register byte addresses.
    localparam logic [7:0] ADDR_SLOT      = 8'h00;
    localparam logic [7:0] ADDR_ERASE     = 8'h04;
    localparam logic [7:0] ADDR_FOLLOW    = 8'h08;
    localparam logic [7:0] ADDR_REPEAT    = 8'h0c;
    localparam logic [7:0] ADDR_RUN       = 8'h10;
    localparam logic [7:0] ADDR_COMMIT    = 8'h14;
    localparam logic [7:0] ADDR_STEP      = 8'h18;
    localparam logic [7:0] ADDR_STEP_CURR = 8'h1c;
    localparam logic [7:0] ADDR_STEP_HOLD = 8'h20;
    localparam logic [7:0] ADDR_TOTAL     = 8'h24;
    localparam logic [7:0] ADDR_STATUS    = 8'h28;

    // Field positions.
    localparam int ERASE_SEL_BIT   = 0;
    localparam int ERASE_ALL_BIT   = 1;
    localparam int RUN_BIT         = 0;
    localparam int STAT_RUN_BIT    = 0;
    localparam int STAT_REJ_BIT    = 1;
    localparam int STAT_STEP_LSB   = 8;
    localparam int STAT_SLOT_LSB   = 16;

    // Widths.
    localparam int SLOT_W = 4;
    localparam int STEP_W = 8;
    localparam int REP_W  = 16;
    localparam int HOLD_W = 18;
    localparam int CURR_W = 16;

    // Value ranges.
    localparam int SLOT_MIN   = 1;
    localparam int SLOT_MAX   = 10;
    localparam int FOLLOW_MIN = 0;
    localparam int REP_MIN    = 1;
    localparam int REP_MAX    = 50000;
    localparam int STEP_MIN   = 1;
    localparam int STEP_MAX   = 150;
    localparam int TOTAL_MIN  = 2;
    localparam int HOLD_MIN   = 1;
    localparam int HOLD_MAX   = 200000;

    // Reset values.
    localparam logic [SLOT_W-1:0] SLOT_RST   = 4'h1;
    localparam logic [SLOT_W-1:0] FOLLOW_RST = 4'h0;
    localparam logic [REP_W-1:0]  REP_RST    = 16'h0001;
    localparam logic [STEP_W-1:0] STEP_RST   = 8'h01;
    localparam logic [STEP_W-1:0] TOTAL_RST  = 8'h02;
    localparam logic [HOLD_W-1:0] HOLD_RST   = 18'h00001;

    // Hold time unit and its cycle count at the 100 MHz system clock.
    localparam real HOLD_UNIT_S = 0.010;
    localparam real CLK_HZ      = 100.0e6;
    localparam int  TICK_CYCLES = int'(HOLD_UNIT_S * CLK_HZ);

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        we;
        logic        re;
    } oss_req_t;

    typedef struct packed {
        logic [CURR_W-1:0] curr;
        logic [HOLD_W-1:0] hold;
    } oss_step_t;

    typedef enum logic {SEQ_IDLE, SEQ_HOLD} oss_seq_t;

endpackage : oss_pkg

// ==== logic/oss_seq_ctrl.sv ====
// Output sequence program controller: slot storage, editing and playback.
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
//
// Functional notes
// - Slot select 1..10, readable back.
// - Erase clears selected slot only.
// - Erase-all clears all ten slots.
// - Follow-on slot 1..10 runs next.
// - Follow-on zero stops after completion.
// - Repeat count 1..50000 passes per slot.
// - Run bit starts, reads executing state.
// - Idle sequence reads as off.
// - Commit copies edit buffer to slot.
// - Step index 1..150 picks edited step.
// - Current set-point stored per step.
// - Set-point drives first channel only.
// - Each step holds 0.010..2000 s.
// - Total step count 2..150 bounds pass.
module oss_seq_ctrl
    import oss_pkg::*;
#(
    parameter int SLOTS      = SLOT_MAX,
    parameter int STEPS      = STEP_MAX,
    parameter int TICK_COUNT = TICK_CYCLES
) (
    input  wire logic              clk_sys_i,
    input  wire logic              rstn_i,
    input  wire oss_req_t          req_i,
    output logic [31:0]            rdata_o,
    output logic [CURR_W-1:0]      ch1_setpoint_o,
    output logic                   running_o,
    output logic [STEP_W-1:0]      active_step_o
);

    localparam int TICK_W = (TICK_COUNT > 1) ? $clog2(TICK_COUNT) : 1;

    if (SLOTS < 1 || SLOTS > 15 || STEPS < TOTAL_MIN || STEPS > 255 || TICK_COUNT < 1) begin : g_bad_param
        $error("oss_seq_ctrl: parameter out of supported range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decoding helpers.

    function automatic logic in_range(input logic [31:0] v, input int lo, input int hi);
        in_range = (v >= 32'(lo)) && (v <= 32'(hi));
    endfunction : in_range

    function automatic logic wr_at(input oss_req_t r, input logic [7:0] a);
        wr_at = r.we && (r.addr == a);
    endfunction : wr_at

    ////////////////////////////////////////////////////////////////////////////
    // State.

    logic [SLOT_W-1:0] sel_slot;
    logic [SLOT_W-1:0] follow_tab [SLOTS];
    logic [REP_W-1:0]  rep_tab    [SLOTS];
    oss_step_t         edit_step  [STEPS];
    logic [STEP_W-1:0] edit_total;
    logic [STEP_W-1:0] step_index;
    oss_step_t         slot_step  [SLOTS][STEPS];
    logic [STEP_W-1:0] slot_total [SLOTS];
    logic [SLOTS-1:0]  slot_valid;
    logic              rejected;

    oss_seq_t          state;
    logic [SLOT_W-1:0] run_slot;
    logic [STEP_W-1:0] act_step;
    logic [REP_W-1:0]  pass_cnt;
    logic [HOLD_W-1:0] hold_left;
    logic [TICK_W-1:0] tick_cnt;

    logic [SLOT_W-1:0] sel_idx;
    logic [STEP_W-1:0] edit_idx;
    logic [STEP_W-1:0] next_step;
    logic [SLOT_W-1:0] follow_run;
    logic              start_req;
    logic              stop_req;
    logic              chk_wr;
    logic              chk_ok;

    assign sel_idx    = sel_slot - SLOT_W'(1);
    assign edit_idx   = step_index - STEP_W'(1);
    assign next_step  = act_step + STEP_W'(1);
    assign follow_run = follow_tab[run_slot];
    assign start_req  = wr_at(req_i, ADDR_RUN) && req_i.wdata[RUN_BIT] && slot_valid[sel_idx];
    assign stop_req   = wr_at(req_i, ADDR_RUN) && !req_i.wdata[RUN_BIT];

    // Range check of every write that carries a bounded value.
    always_comb begin
        chk_wr = 1'b0;
        chk_ok = 1'b1;
        if (req_i.we) begin
            unique case (req_i.addr)
                ADDR_SLOT:      begin chk_wr = 1'b1; chk_ok = in_range(req_i.wdata, SLOT_MIN, SLOTS); end
                ADDR_FOLLOW:    begin chk_wr = 1'b1; chk_ok = in_range(req_i.wdata, FOLLOW_MIN, SLOTS); end
                ADDR_REPEAT:    begin chk_wr = 1'b1; chk_ok = in_range(req_i.wdata, REP_MIN, REP_MAX); end
                ADDR_STEP:      begin chk_wr = 1'b1; chk_ok = in_range(req_i.wdata, STEP_MIN, STEPS); end
                ADDR_STEP_HOLD: begin chk_wr = 1'b1; chk_ok = in_range(req_i.wdata, HOLD_MIN, HOLD_MAX); end
                ADDR_TOTAL:     begin chk_wr = 1'b1; chk_ok = in_range(req_i.wdata, TOTAL_MIN, STEPS); end
                ADDR_STEP_CURR: begin chk_wr = 1'b1; chk_ok = (req_i.wdata[31:CURR_W] == '0); end
                ADDR_RUN:       begin chk_wr = 1'b1; chk_ok = !req_i.wdata[RUN_BIT] || slot_valid[sel_idx]; end
                default:        begin chk_wr = 1'b0; chk_ok = 1'b1; end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Slot settings: selection, follow-on and repeat count.

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sel_slot <= SLOT_RST;
        end else if (wr_at(req_i, ADDR_SLOT) && chk_ok) begin
            sel_slot <= req_i.wdata[SLOT_W-1:0];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int s = 0; s < SLOTS; s++) begin
                follow_tab[s] <= FOLLOW_RST;
                rep_tab[s]    <= REP_RST;
            end
        end else begin
            if (wr_at(req_i, ADDR_FOLLOW) && chk_ok) begin
                follow_tab[sel_idx] <= req_i.wdata[SLOT_W-1:0];
            end
            if (wr_at(req_i, ADDR_REPEAT) && chk_ok) begin
                rep_tab[sel_idx] <= req_i.wdata[REP_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rejected <= 1'b0;
        end else if (chk_wr) begin
            rejected <= !chk_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Edit buffer: the sequence being programmed before it is committed.

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            step_index <= STEP_RST;
            edit_total <= TOTAL_RST;
            for (int i = 0; i < STEPS; i++) begin
                edit_step[i] <= '{curr: '0, hold: HOLD_RST};
            end
        end else begin
            if (wr_at(req_i, ADDR_STEP) && chk_ok) begin
                step_index <= req_i.wdata[STEP_W-1:0];
            end
            if (wr_at(req_i, ADDR_TOTAL) && chk_ok) begin
                edit_total <= req_i.wdata[STEP_W-1:0];
            end
            if (wr_at(req_i, ADDR_STEP_CURR) && chk_ok) begin
                edit_step[edit_idx].curr <= req_i.wdata[CURR_W-1:0];
            end
            if (wr_at(req_i, ADDR_STEP_HOLD) && chk_ok) begin
                edit_step[edit_idx].hold <= req_i.wdata[HOLD_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Slot store. Erasure zeroes the steps and marks the slot empty, so an
    // erased slot can neither be started nor chained into.

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            slot_valid <= '0;
            for (int s = 0; s < SLOTS; s++) begin
                slot_total[s] <= '0;
                for (int i = 0; i < STEPS; i++) begin
                    slot_step[s][i] <= '0;
                end
            end
        end else begin
            for (int s = 0; s < SLOTS; s++) begin
                if (req_i.we && req_i.addr == ADDR_ERASE &&
                    (req_i.wdata[ERASE_ALL_BIT] || (req_i.wdata[ERASE_SEL_BIT] && SLOT_W'(s) == sel_idx))) begin
                    slot_valid[s] <= 1'b0;
                    slot_total[s] <= '0;
                    for (int i = 0; i < STEPS; i++) begin
                        slot_step[s][i] <= '0;
                    end
                end else if (wr_at(req_i, ADDR_COMMIT) && SLOT_W'(s) == sel_idx) begin
                    slot_valid[s] <= 1'b1;
                    slot_total[s] <= edit_total;
                    for (int i = 0; i < STEPS; i++) begin
                        slot_step[s][i] <= edit_step[i];
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Playback. The tick divides the clock down to the hold unit; the hold
    // counter then counts whole units, so a step lasts hold * unit exactly.

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state     <= SEQ_IDLE;
            run_slot  <= '0;
            act_step  <= '0;
            pass_cnt  <= '0;
            hold_left <= '0;
            tick_cnt  <= '0;
        end else begin
            unique case (state)
                SEQ_IDLE: begin
                    if (start_req) begin
                        state     <= SEQ_HOLD;
                        run_slot  <= sel_idx;
                        act_step  <= '0;
                        pass_cnt  <= REP_W'(1);
                        hold_left <= slot_step[sel_idx][0].hold;
                        tick_cnt  <= '0;
                    end
                end
                SEQ_HOLD: begin
                    if (stop_req) begin
                        state <= SEQ_IDLE;
                    end else if (tick_cnt != TICK_W'(TICK_COUNT - 1)) begin
                        tick_cnt <= tick_cnt + TICK_W'(1);
                    end else begin
                        tick_cnt <= '0;
                        if (hold_left > HOLD_W'(1)) begin
                            hold_left <= hold_left - HOLD_W'(1);
                        end else if (next_step < slot_total[run_slot]) begin
                            act_step  <= next_step;
                            hold_left <= slot_step[run_slot][next_step].hold;
                        end else if (pass_cnt < rep_tab[run_slot]) begin
                            pass_cnt  <= pass_cnt + REP_W'(1);
                            act_step  <= '0;
                            hold_left <= slot_step[run_slot][0].hold;
                        end else if (follow_run != '0 && slot_valid[follow_run - SLOT_W'(1)]) begin
                            run_slot  <= follow_run - SLOT_W'(1);
                            pass_cnt  <= REP_W'(1);
                            act_step  <= '0;
                            hold_left <= slot_step[follow_run - SLOT_W'(1)][0].hold;
                        end else begin
                            state <= SEQ_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Outputs lag the playback state by one cycle to come from flip-flops.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            running_o      <= 1'b0;
            active_step_o  <= '0;
            ch1_setpoint_o <= '0;
        end else begin
            running_o      <= (state == SEQ_HOLD);
            active_step_o  <= (state == SEQ_HOLD) ? next_step : '0;
            ch1_setpoint_o <= (state == SEQ_HOLD) ? slot_step[run_slot][act_step].curr : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port: data stand in the cycle after the read strobe only.

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= '0;
        end else if (!req_i.re) begin
            rdata_o <= '0;
        end else begin
            unique case (req_i.addr)
                ADDR_SLOT:      rdata_o <= 32'(sel_slot);
                ADDR_FOLLOW:    rdata_o <= 32'(follow_tab[sel_idx]);
                ADDR_REPEAT:    rdata_o <= 32'(rep_tab[sel_idx]);
                ADDR_RUN:       rdata_o <= 32'(state == SEQ_HOLD);
                ADDR_STEP:      rdata_o <= 32'(step_index);
                ADDR_STEP_CURR: rdata_o <= 32'(edit_step[edit_idx].curr);
                ADDR_STEP_HOLD: rdata_o <= 32'(edit_step[edit_idx].hold);
                ADDR_TOTAL:     rdata_o <= 32'(edit_total);
                ADDR_STATUS: begin
                    rdata_o                              <= '0;
                    rdata_o[STAT_RUN_BIT]                <= (state == SEQ_HOLD);
                    rdata_o[STAT_REJ_BIT]                <= rejected;
                    rdata_o[STAT_STEP_LSB +: STEP_W]     <= (state == SEQ_HOLD) ? next_step : '0;
                    rdata_o[STAT_SLOT_LSB +: SLOT_W]     <= (state == SEQ_HOLD) ? run_slot + SLOT_W'(1) : '0;
                end
                default:        rdata_o <= '0;
            endcase
        end
    end

endmodule : oss_seq_ctrl

// ==== verification/oss_seq_ctrl_asserts.sv ====
// Port-level checker for the output sequence program controller.
`timescale 1ns/1ps
module oss_seq_ctrl_asserts
    import oss_pkg::*;
#(
    parameter int STEPS = STEP_MAX
) (
    input wire logic              clk_sys_i,
    input wire logic              rstn_i,
    input wire oss_req_t          req_i,
    input wire logic [31:0]       rdata_o,
    input wire logic [CURR_W-1:0] ch1_setpoint_o,
    input wire logic              running_o,
    input wire logic [STEP_W-1:0] active_step_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rstn_i);
    ////////////////////////////////////////////////////////////////////////////
    sequence s_rd(logic [7:0] a);
        req_i.re && req_i.addr == a;
    endsequence
    sequence s_wr(logic [7:0] a);
        req_i.we && req_i.addr == a;
    endsequence
    property p_slot;
        s_rd(ADDR_SLOT) |=> rdata_o inside {[SLOT_MIN:SLOT_MAX]};
    endproperty
    property p_follow;
        s_rd(ADDR_FOLLOW) |=> rdata_o <= SLOT_MAX;
    endproperty
    property p_repeat;
        s_rd(ADDR_REPEAT) |=> rdata_o inside {[REP_MIN:REP_MAX]};
    endproperty
    property p_step_idx;
        s_rd(ADDR_STEP) |=> rdata_o inside {[STEP_MIN:STEP_MAX]};
    endproperty
    property p_curr;
        s_rd(ADDR_STEP_CURR) |=> rdata_o[31:CURR_W] == '0;
    endproperty
    property p_idle;
        !running_o |-> ch1_setpoint_o == '0 && active_step_o == '0;
    endproperty
    property p_step_range;
        running_o |-> active_step_o inside {[1:STEPS]};
    endproperty
    // A step may only advance by one or wrap to the first step of a new pass.
    property p_ascend;
        running_o && $past(running_o) && $changed(active_step_o)
            |-> active_step_o == $past(active_step_o) + 8'h01 || active_step_o == 8'h01;
    endproperty
    property p_hold;
        running_o && $changed(active_step_o) |=> $stable(active_step_o) || !running_o;
    endproperty
    property p_stop;
        s_wr(ADDR_RUN) ##0 !req_i.wdata[RUN_BIT] |-> ##2 !running_o;
    endproperty
    a_slot:       assert property (p_slot)       else $error("slot readback out of range");
    a_follow:     assert property (p_follow)     else $error("follow-on readback out of range");
    a_repeat:     assert property (p_repeat)     else $error("repeat readback out of range");
    a_step_idx:   assert property (p_step_idx)   else $error("step index readback out of range");
    a_curr:       assert property (p_curr)       else $error("set-point readback too wide");
    a_idle:       assert property (p_idle)       else $error("outputs not zero while idle");
    a_step_range: assert property (p_step_range) else $error("playing step out of range");
    a_ascend:     assert property (p_ascend)     else $error("step order broken");
    a_hold:       assert property (p_hold)       else $error("step held too briefly");
    a_stop:       assert property (p_stop)       else $error("stop command ignored");
endmodule : oss_seq_ctrl_asserts

bind oss_seq_ctrl oss_seq_ctrl_asserts #(.STEPS(STEPS)) u_oss_chk (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .req_i(req_i), .rdata_o(rdata_o),
    .ch1_setpoint_o(ch1_setpoint_o), .running_o(running_o), .active_step_o(active_step_o));

// ==== verification/oss_host.sv ====
// Host model that issues register commands to the sequence controller.
`timescale 1ns/1ps
module oss_host
    import oss_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic [31:0] rdata_i,
    output oss_req_t         req_o
);
    initial req_o = '0;
    // A released bus shows the inverse of the last command, so no stale value looks valid.
    task automatic idle();
        req_o <= '{addr: ~req_o.addr, wdata: ~req_o.wdata, we: 1'b0, re: 1'b0};
    endtask : idle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        req_o <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge clk_sys_i);
        idle();
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys_i);
        req_o <= '{addr: a, wdata: ~req_o.wdata, we: 1'b0, re: 1'b1};
        @(posedge clk_sys_i);
        idle();
        #1 d = rdata_i;
    endtask : rd
endmodule : oss_host

// ==== verification/oss_seq_ctrl_bench.sv ====
// Self-checking bench for the output sequence program controller.
`timescale 1ns/1ps
module oss_seq_ctrl_bench
    import oss_pkg::*;
;
    // Short tick so that every step lasts only a few clock cycles.
    localparam int TICK = 2;
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
    logic              clk_sys_i = 1'b0;
    logic              rstn_i    = 1'b0;
    oss_req_t          req;
    logic [31:0]       rdata;
    logic [CURR_W-1:0] setpoint;
    logic              running;
    logic [STEP_W-1:0] step;
    int                num_errors = 0;
    int                n_tests    = 0;
    int                seed       = 80605;
    logic [31:0]       v;
    logic [31:0]       cur;
    logic [CURR_W-1:0] curr [3];
    logic [STEP_W-1:0] seen [$];
    logic [STEP_W-1:0] want [$];
    int                dur  [$];
    logic [7:0]  addrs [6] = '{ADDR_SLOT, ADDR_FOLLOW, ADDR_REPEAT, ADDR_STEP, ADDR_TOTAL, ADDR_STEP_HOLD};
    int          lo [6]    = '{SLOT_MIN, FOLLOW_MIN, REP_MIN, STEP_MIN, TOTAL_MIN, HOLD_MIN};
    int          hi [6]    = '{SLOT_MAX, SLOT_MAX, REP_MAX, STEP_MAX, STEP_MAX, HOLD_MAX};
    logic [31:0] rst [6]   = '{32'(SLOT_RST), 32'(FOLLOW_RST), 32'(REP_RST), 32'(STEP_RST), 32'(TOTAL_RST),
                               32'(HOLD_RST)};
    always #5 clk_sys_i = ~clk_sys_i;
    oss_seq_ctrl #(.TICK_COUNT(TICK)) dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .req_i(req), .rdata_o(rdata),
        .ch1_setpoint_o(setpoint), .running_o(running), .active_step_o(step));
    oss_host host (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .req_o(req));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] keep_or(logic [31:0] old, logic [31:0] n, int l, int h);
        return (n >= l && n <= h) ? n : old;
    endfunction : keep_or
    function automatic void add_passes(int tot, int reps);
        repeat (reps) for (int s = 1; s <= tot; s++) want.push_back(8'(s));
    endfunction : add_passes
    function automatic int step_hold(int s);
        return (s == 1) ? 2 : 1;
    endfunction : step_hold
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        host.rd(a, r);
        `CHK(nm, e, r)
    endtask : rd_chk
    task automatic rej_chk(input logic e);
        logic [31:0] r;
        host.rd(ADDR_STATUS, r);
        `CHK("rejected", e, r[STAT_REJ_BIT])
    endtask : rej_chk
    task automatic try_start(input logic e);
        host.wr(ADDR_RUN, 32'h1);
        repeat (2) @(posedge clk_sys_i);
        #1 `CHK("running", e, running)
        rd_chk("run", ADDR_RUN, {31'h0, e});
        rej_chk(~e);
        host.wr(ADDR_RUN, 32'h0);
        repeat (2) @(posedge clk_sys_i);
        #1 `CHK("stopped", 1'b0, running)
    endtask : try_start
    task automatic results();
        if (num_errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        num_errors++;
        results();
    end
    initial begin
        repeat (8) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        for (int i = 0; i < 6; i++) rd_chk("reset", addrs[i], rst[i]);
        rd_chk("unmapped", 8'h2c, 32'h0);
        for (int i = 0; i < 6; i++) begin
            cur = rst[i];
            for (int k = 0; k < 4; k++) begin
                v = (k == 0) ? hi[i] + 1 : (k == 1) ? lo[i] - 1 : (k == 2) ? hi[i] :
                    lo[i] + $unsigned($random(seed)) % (hi[i] - lo[i] + 1);
                host.wr(addrs[i], v);
                cur = keep_or(cur, v, lo[i], hi[i]);
                rd_chk("value", addrs[i], cur);
                rej_chk(cur !== v);
            end
        end
        // Slot one was never committed, so a start there must be refused.
        host.wr(ADDR_SLOT, 32'h1);
        try_start(1'b0);
        host.wr(ADDR_TOTAL, 32'h2);
        for (int s = 1; s <= 3; s++) begin
            curr[s-1] = CURR_W'($random(seed));
            host.wr(ADDR_STEP, s);
            host.wr(ADDR_STEP_CURR, 32'(curr[s-1]));
            host.wr(ADDR_STEP_HOLD, step_hold(s));
        end
        host.wr(ADDR_STEP, 32'h2);
        rd_chk("curr", ADDR_STEP_CURR, 32'(curr[1]));
        host.wr(ADDR_STEP_CURR, 32'h1 << CURR_W);
        rej_chk(1'b1);
        rd_chk("curr kept", ADDR_STEP_CURR, 32'(curr[1]));
        host.wr(ADDR_SLOT, 32'h3);
        host.wr(ADDR_COMMIT, 32'h0);
        host.wr(ADDR_REPEAT, 32'h1);
        host.wr(ADDR_FOLLOW, 32'h0);
        host.wr(ADDR_TOTAL, 32'h3);
        host.wr(ADDR_SLOT, 32'h2);
        host.wr(ADDR_COMMIT, 32'h0);
        host.wr(ADDR_REPEAT, 32'h2);
        host.wr(ADDR_FOLLOW, 32'h3);
        rd_chk("slot", ADDR_SLOT, 32'h2);
        rd_chk("follow", ADDR_FOLLOW, 32'h3);
        add_passes(3, 2);
        add_passes(2, 1);
        host.wr(ADDR_RUN, 32'h1);
        // One edge after the start is taken the first step is already shown, so its full length is counted.
        @(posedge clk_sys_i);
        #1;
        for (int n = 0; n < 400 && running === 1'b1; n++) begin
            if (seen.size() == 0 || seen[$] !== step) begin
                seen.push_back(step);
                dur.push_back(0);
            end
            dur[dur.size()-1]++;
            `CHK("setpoint", curr[step-1], setpoint)
            @(posedge clk_sys_i);
            #1;
        end
        `CHK("step count", want.size(), seen.size())
        foreach (want[i]) `CHK("step", want[i], seen[i])
        foreach (want[i]) `CHK("step time", step_hold(want[i]) * TICK, dur[i])
        try_start(1'b1);
        host.wr(ADDR_ERASE, 32'h1 << ERASE_SEL_BIT);
        try_start(1'b0);
        host.wr(ADDR_SLOT, 32'h3);
        try_start(1'b1);
        host.wr(ADDR_ERASE, 32'h1 << ERASE_ALL_BIT);
        try_start(1'b0);
        results();
    end
endmodule : oss_seq_ctrl_bench
